// ===== design/tlp_defs.svh
// Numeric constants for the thermal line printer host port
`ifndef TLP_DEFS_SVH
`define TLP_DEFS_SVH

// Line geometry
`define TLP_LINE_BYTES     48
`define TLP_BYTE_BITS      8

// Write command addresses
`define TLP_CMD_RESET      4'h0
`define TLP_CMD_ADVANCE    4'h1
`define TLP_CMD_LOAD       4'h2
`define TLP_CMD_LATCH      4'h3
`define TLP_CMD_PRINT_ADV  4'h4
`define TLP_CMD_PRINT      4'h5

// Read addresses
`define TLP_RD_IDENTITY    4'h0
`define TLP_RD_STATUS      4'h1

// Status bit positions
`define TLP_ST_ADV_RDY     4
`define TLP_ST_ACCEPT      5
`define TLP_ST_PRN_RDY     6
`define TLP_ST_NO_FAULT    7

// Identity value, arbitrary
`define TLP_ID_CODE        8'h5A

// Timing
`define TLP_CLK_PERIOD_NS  40
`define TLP_PRINT_TIME_NS  2500000
`define TLP_ADV_TIME_NS    4000000
`define TLP_LOAD_TIME_NS   5000
`define TLP_PRINT_CYCLES   (`TLP_PRINT_TIME_NS / `TLP_CLK_PERIOD_NS)
`define TLP_ADV_CYCLES     (`TLP_ADV_TIME_NS / `TLP_CLK_PERIOD_NS)
`define TLP_LOAD_CYCLES    (`TLP_LOAD_TIME_NS / `TLP_CLK_PERIOD_NS)

`endif

// ===== design/tlp_pkg.sv
// Types shared by the thermal line printer host port
package tlp_pkg;

    typedef enum logic [2:0] {
        TLP_IDLE,
        TLP_LOADING,
        TLP_PRINTING,
        TLP_ADVANCING
    } tlp_state_t;

endpackage

// ===== design/tlp_head_chain.sv
// Printhead shift chain and output latch for one print line
`timescale 1ns/1ps

module tlp_head_chain #(
    parameter int NBYTES = 48
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic                  shift_en,
    input  wire logic [7:0]            byte_in,
    input  wire logic                  latch_en,
    output logic      [NBYTES*8-1:0]   latched_q
);

    logic [NBYTES*8-1:0] chain_q;

    // Byte 0 is the leftmost position; bytes travel toward higher indices
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            chain_q <= '0;
        end else if (shift_en) begin
            chain_q <= {chain_q[NBYTES*8-9:0], byte_in}; // [R3] [R4]
        end
    end

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            latched_q <= '0;
        end else if (latch_en) begin
            latched_q <= chain_q; // [R8]
        end
    end

endmodule

// ===== design/tlp_host_port.sv
// Host command port of the thermal line printer: decode, sequencing, status
`timescale 1ns/1ps
`include "tlp_defs.svh"

//
// Contract
// R1: Holds one line of 384 dots, loaded as 48 bytes.
// R2: A one bit energizes its dot when printed; zero leaves it off.
// R3: Bytes shift left to right; each new byte pushes the oldest out.
// R4: A partial load prints leftover old bytes with new ones shifted left.
// R5: Host keeps lit dots per print at or below a quarter of the line.
// R6: Load captures the data byte, shifts it in, drops accept-data until ready.
// R7: Host loads only while accept-data reads one.
// R8: Latch copies the shifted chain into the output latch for printing.
// R9: Host latches after a full line, with print-ready and accept-data high.
// R10: Print-only prints the latched line, no paper move, print-ready low meanwhile.
// R11: Host sends print-only only while print-ready reads one.
// R12: Advance moves paper one eighth-millimetre line without printing.
// R13: Host advances only while advance-ready reads one.
// R14: Print-and-advance prints then advances, ready bits low while busy; accept-data stays high, only print-ready and advance-ready drop.
// R15: Host sends print-and-advance only with print-ready and advance-ready high.
// R16: Reset command abandons activity and returns to idle.
// R17: Host polls status after reset before further commands.
// R18: Identify read returns a fixed eight-bit identity value.
// R19: Status: bit6 print-ready, bit5 accept-data, bit4 advance-ready, bit7 fault.
// R20: Host reads status and waits for ready bits before any command.
// R21: Bit7 reads zero with a fault, one without; bits 3..0 zero.
// R22: Writes: 0 reset, 1 advance, 2 load, 3 latch, 4 print+advance, 5 print.
// R23: Read 0 identity, read 1 status, others unused.
// R24: Commands use address lines with select low plus read or write low.
// R25: Ready bits drop on taking a command and rise when it completes.
// R26: After reset command, all ready bits read one unless faulted.
module tlp_host_port #(
    parameter int         NBYTES       = `TLP_LINE_BYTES,
    parameter int         PRINT_CYCLES = `TLP_PRINT_CYCLES,
    parameter int         ADV_CYCLES   = `TLP_ADV_CYCLES,
    parameter int         LOAD_CYCLES  = `TLP_LOAD_CYCLES,
    parameter logic [7:0] ID_CODE      = `TLP_ID_CODE
) (
    input  wire logic                  mclk,
    input  wire logic                  rst_n,
    input  wire logic [3:0]            addr,
    input  wire logic [7:0]            data_in,
    output logic      [7:0]            data_out,
    output logic                       data_oe,
    input  wire logic                  unit_select_n,
    input  wire logic                  rd_n,
    input  wire logic                  wr_n,
    input  wire logic                  head_fault,
    output logic      [NBYTES*8-1:0]   head_dots,
    output logic                       head_energize,
    output logic                       paper_step
);

    localparam int MAXC = (PRINT_CYCLES > ADV_CYCLES) ?
                          ((PRINT_CYCLES > LOAD_CYCLES) ? PRINT_CYCLES : LOAD_CYCLES) :
                          ((ADV_CYCLES > LOAD_CYCLES) ? ADV_CYCLES : LOAD_CYCLES);
    localparam int CW   = $clog2(MAXC + 1);

    tlp_pkg::tlp_state_t state_q;
    logic [CW-1:0]       cnt_q;
    logic                then_adv_q;
    logic                accept_q;
    logic                prn_rdy_q;
    logic                adv_rdy_q;
    logic                wr_seen_q;
    logic                wr_act;
    logic                rd_act;
    logic                cmd_take;
    logic                idle_take;
    logic                shift_en;
    logic                latch_en;
    logic                cnt_done;
    logic [7:0]          status;
    logic [NBYTES*8-1:0] latched;

    // Strobe decode: a write is taken once, on the first cycle it is seen
    assign wr_act    = !unit_select_n && !wr_n; // [R24]
    assign rd_act    = !unit_select_n && !rd_n; // [R24]
    assign cmd_take  = wr_act && !wr_seen_q;
    // Busy commands arriving mid-operation or under fault are dropped
    assign idle_take = cmd_take && (state_q == tlp_pkg::TLP_IDLE) && !head_fault;
    assign shift_en  = idle_take && (addr == `TLP_CMD_LOAD); // [R6] [R22]
    assign latch_en  = idle_take && (addr == `TLP_CMD_LATCH); // [R8] [R22]
    assign cnt_done  = (cnt_q == '0);

    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            wr_seen_q <= 1'b0;
        end else begin
            wr_seen_q <= wr_act;
        end
    end

    // Command sequencer and ready flags
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            state_q    <= tlp_pkg::TLP_IDLE;
            cnt_q      <= '0;
            then_adv_q <= 1'b0;
            accept_q   <= 1'b1;
            prn_rdy_q  <= 1'b1;
            adv_rdy_q  <= 1'b1;
        end else if (cmd_take && addr == `TLP_CMD_RESET) begin
            // Reset wins over anything in progress
            state_q    <= tlp_pkg::TLP_IDLE; // [R16] [R22]
            cnt_q      <= '0;
            then_adv_q <= 1'b0;
            accept_q   <= 1'b1; // [R26]
            prn_rdy_q  <= 1'b1; // [R26]
            adv_rdy_q  <= 1'b1; // [R26]
        end else begin
            unique case (state_q)
                tlp_pkg::TLP_IDLE: begin
                    if (idle_take) begin
                        unique case (addr)
                            `TLP_CMD_ADVANCE: begin
                                state_q   <= tlp_pkg::TLP_ADVANCING; // [R12]
                                cnt_q     <= CW'(ADV_CYCLES - 1);
                                adv_rdy_q <= 1'b0; // [R25]
                            end
                            `TLP_CMD_LOAD: begin
                                state_q  <= tlp_pkg::TLP_LOADING;
                                cnt_q    <= CW'(LOAD_CYCLES - 1);
                                accept_q <= 1'b0; // [R6] [R25]
                            end
                            `TLP_CMD_PRINT_ADV: begin
                                state_q    <= tlp_pkg::TLP_PRINTING; // [R14]
                                cnt_q      <= CW'(PRINT_CYCLES - 1);
                                then_adv_q <= 1'b1;
                                prn_rdy_q  <= 1'b0; // [R14] [R25]
                                adv_rdy_q  <= 1'b0; // [R14] [R25]
                            end
                            `TLP_CMD_PRINT: begin
                                state_q    <= tlp_pkg::TLP_PRINTING; // [R10]
                                cnt_q      <= CW'(PRINT_CYCLES - 1);
                                then_adv_q <= 1'b0;
                                prn_rdy_q  <= 1'b0; // [R10] [R25]
                            end
                            default: begin
                                // Latch is immediate; 6..F are ignored
                                state_q <= tlp_pkg::TLP_IDLE; // [R22]
                            end
                        endcase
                    end
                end
                tlp_pkg::TLP_LOADING: begin
                    if (cnt_done) begin
                        state_q  <= tlp_pkg::TLP_IDLE;
                        accept_q <= 1'b1; // [R6] [R25]
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                tlp_pkg::TLP_PRINTING: begin
                    if (cnt_done && then_adv_q) begin
                        // Print ready stays low until the paper has moved too
                        state_q <= tlp_pkg::TLP_ADVANCING; // [R14]
                        cnt_q   <= CW'(ADV_CYCLES - 1);
                    end else if (cnt_done) begin
                        state_q   <= tlp_pkg::TLP_IDLE;
                        prn_rdy_q <= 1'b1; // [R10] [R25]
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                tlp_pkg::TLP_ADVANCING: begin
                    if (cnt_done) begin
                        state_q    <= tlp_pkg::TLP_IDLE;
                        then_adv_q <= 1'b0;
                        adv_rdy_q  <= 1'b1; // [R25]
                        prn_rdy_q  <= 1'b1; // [R14] [R25]
                    end else begin
                        cnt_q <= cnt_q - 1'b1;
                    end
                end
                default: begin
                    state_q <= tlp_pkg::TLP_IDLE;
                end
            endcase
        end
    end

    // Line storage; the chain length fixes the line width
    tlp_head_chain #(
        .NBYTES    (NBYTES)
    ) u_chain (
        .mclk      (mclk),
        .rst_n     (rst_n),
        .shift_en  (shift_en),
        .byte_in   (data_in), // [R6]
        .latch_en  (latch_en),
        .latched_q (latched) // [R1]
    );

    // Printhead drive: dots follow latched bits only while the head is energized,
    // so no stale line sits on the dot lines in the last print cycle
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            head_dots     <= '0;
            head_energize <= 1'b0;
        end else begin
            head_energize <= (state_q == tlp_pkg::TLP_PRINTING) && !cnt_done;
            head_dots     <= ((state_q == tlp_pkg::TLP_PRINTING) && !cnt_done) ?
                             latched : '0; // [R2]
        end
    end

    // One step pulse per line advance; the motor driver does the rest
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            paper_step <= 1'b0;
        end else begin
            paper_step <= (state_q != tlp_pkg::TLP_ADVANCING) &&
                          (((state_q == tlp_pkg::TLP_IDLE) && idle_take &&
                            (addr == `TLP_CMD_ADVANCE)) ||
                           ((state_q == tlp_pkg::TLP_PRINTING) && cnt_done &&
                            then_adv_q && !(cmd_take && addr == `TLP_CMD_RESET))); // [R12] [R14]
        end
    end

    // Ready bits read as zero under fault so the host never issues work
    always_comb begin
        status                    = 8'h00; // [R21]
        status[`TLP_ST_NO_FAULT]  = !head_fault; // [R21]
        status[`TLP_ST_PRN_RDY]   = prn_rdy_q && !head_fault; // [R19]
        status[`TLP_ST_ACCEPT]    = accept_q && !head_fault; // [R19]
        status[`TLP_ST_ADV_RDY]   = adv_rdy_q && !head_fault; // [R19]
    end

    // Read data is registered: valid from the second cycle of a read strobe
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n) begin
            data_out <= 8'h00;
        end else if (rd_act) begin
            unique case (addr)
                `TLP_RD_IDENTITY: data_out <= ID_CODE; // [R18] [R23]
                `TLP_RD_STATUS:   data_out <= status; // [R19] [R23]
                default:          data_out <= 8'h00; // [R23]
            endcase
        end
    end

    assign data_oe = rd_act;

endmodule

// ===== test/tlp_host_port_asserts.sv
// Port checker for the thermal line printer host port
`timescale 1ns/1ps
module tlp_host_port_chk #(
    parameter int         NBYTES       = 48,
    parameter int         PRINT_CYCLES = 20,
    parameter logic [7:0] ID_CODE      = 8'h00
) (
    input wire logic                mclk,
    input wire logic                rst_n,
    input wire logic [3:0]          addr,
    input wire logic [7:0]          data_out,
    input wire logic                data_oe,
    input wire logic                unit_select_n,
    input wire logic                rd_n,
    input wire logic                head_fault,
    input wire logic [NBYTES*8-1:0] head_dots,
    input wire logic                head_energize,
    input wire logic                paper_step
);
    logic        rd_act;
    logic [15:0] run_q;
    assign rd_act = !unit_select_n && !rd_n;
    // Length of each energize burst, checked when it ends
    always_ff @(posedge mclk or negedge rst_n) begin
        if (!rst_n)
            run_q <= 16'h0000;
        else
            run_q <= head_energize ? run_q + 16'h0001 : 16'h0000;
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n);
    oe_read_a: assert property (data_oe == rd_act)
        else $error("data_oe does not follow the read strobes");
    id_read_a: assert property (rd_act && addr == 4'h0 |=> data_out == ID_CODE)
        else $error("identity read wrong");
    stat_low_a: assert property (rd_act && addr == 4'h1 |=> data_out[3:0] == 4'h0)
        else $error("unused status bits set");
    fault_bit_a: assert property (rd_act && addr == 4'h1 |=> data_out[7] == !$past(head_fault))
        else $error("fault bit wrong");
    unused_rd_a: assert property (rd_act && addr > 4'h1 |=> data_out == 8'h00)
        else $error("unused read not zero");
    dots_idle_a: assert property (!head_energize |-> head_dots == '0)
        else $error("dots driven outside a print");
    step_pulse_a: assert property (paper_step |=> !paper_step)
        else $error("paper step longer than one cycle");
    print_still_a: assert property (head_energize |-> !paper_step)
        else $error("paper moved while printing");
    print_len_a: assert property ($fell(head_energize) |-> run_q == 16'(PRINT_CYCLES - 1))
        else $error("print burst length wrong");
endmodule

bind tlp_host_port tlp_host_port_chk #(.NBYTES(NBYTES), .PRINT_CYCLES(PRINT_CYCLES),
    .ID_CODE(ID_CODE)) tlp_host_port_chk_i (.mclk(mclk), .rst_n(rst_n), .addr(addr),
    .data_out(data_out), .data_oe(data_oe), .unit_select_n(unit_select_n), .rd_n(rd_n),
    .head_fault(head_fault), .head_dots(head_dots), .head_energize(head_energize),
    .paper_step(paper_step));

// ===== test/tlp_host_model.sv
// Host processor model driving the recorder command bus
`timescale 1ns/1ps
module tlp_host_model (
    input  wire logic       mclk,
    output logic      [3:0] addr,
    output logic      [7:0] data_in,
    input  wire logic [7:0] data_out,
    output logic            unit_select_n,
    output logic            rd_n,
    output logic            wr_n
);
    initial begin
        addr = 4'hF;
        data_in = 8'hFF;
        unit_select_n = 1'b1;
        rd_n = 1'b1;
        wr_n = 1'b1;
    end
    // Released lines show the inverse so stale values never look valid
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        data_in <= d;
        unit_select_n <= 1'b0;
        wr_n <= 1'b0;
        @(posedge mclk);
        addr <= ~a;
        data_in <= ~d;
        unit_select_n <= 1'b1;
        wr_n <= 1'b1;
        @(posedge mclk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        unit_select_n <= 1'b0;
        rd_n <= 1'b0;
        @(posedge mclk);
        @(posedge mclk);
        d = data_out;
        addr <= ~a;
        unit_select_n <= 1'b1;
        rd_n <= 1'b1;
    endtask
    // Poll up to 200 status reads until every bit of the mask is set
    task automatic wait_rdy(input logic [7:0] m, output logic ok);
        logic [7:0] s;
        ok = 1'b0;
        for (int i = 0; i < 200 && !ok; i++) begin
            rd(4'h1, s);
            ok = ((s & m) === m);
        end
    endtask
endmodule

// ===== test/test_thermal_line_printer_host_port.sv
// Self-checking testbench for the thermal line printer host port
`timescale 1ns/1ps
`include "tlp_defs.svh"
module test_thermal_line_printer_host_port;
    localparam logic [7:0] ID = `TLP_ID_CODE;
    logic         mclk, rst_n, data_oe, unit_select_n, rd_n, wr_n;
    logic         head_fault, head_energize, paper_step;
    logic [3:0]   addr;
    logic [7:0]   data_in, data_out, s;
    logic [383:0] head_dots;
    logic [7:0]   exp_q [48];
    int           err_total = 0, check_count = 0, steps = 0, s0;
    // Only the millisecond operations are shortened; load time and identity stay as built
    tlp_host_port #(.PRINT_CYCLES(20), .ADV_CYCLES(30))
    tlp_host_port_i (.mclk(mclk), .rst_n(rst_n), .addr(addr), .data_in(data_in),
        .data_out(data_out), .data_oe(data_oe), .unit_select_n(unit_select_n), .rd_n(rd_n),
        .wr_n(wr_n), .head_fault(head_fault), .head_dots(head_dots),
        .head_energize(head_energize), .paper_step(paper_step));
    tlp_host_model tlp_host_model_i (.mclk(mclk), .addr(addr), .data_in(data_in),
        .data_out(data_out), .unit_select_n(unit_select_n), .rd_n(rd_n), .wr_n(wr_n));
    initial begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end
    always @(posedge mclk) if (paper_step === 1'b1) steps++;
    task automatic check(input logic [383:0] seen, input logic [383:0] want);
        check_count++;
        if (seen !== want) begin
            err_total++;
            $display("BAD %0t seen %0h want %0h", $time, seen, want);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    // Polls status; a poll that never sees the mask counts as a mismatch
    task automatic ready(input logic [7:0] m);
        logic ok;
        tlp_host_model_i.wait_rdy(m, ok);
        check(ok, 1'b1);
    endtask
    task automatic load(input logic [7:0] v);
        ready(8'h20);
        tlp_host_model_i.wr(4'h2, v);
        for (int j = 47; j > 0; j--) exp_q[j] = exp_q[j-1];
        exp_q[0] = v;
    endtask
    // Latch, print without advance and compare the energized dots
    task automatic print_chk();
        logic [383:0] want;
        for (int j = 0; j < 48; j++) want[8*j+:8] = exp_q[j];
        s0 = steps;
        ready(8'h60);
        tlp_host_model_i.wr(4'h3, 8'h00);
        tlp_host_model_i.wr(4'h5, 8'h00);
        tlp_host_model_i.rd(4'h1, s);
        check(s[6], 1'b0);
        check(head_energize, 1'b1);
        check(head_dots, want);
        ready(8'h40);
        check(steps, s0);
    endtask
    task automatic t_regs();
        tlp_host_model_i.rd(4'h0, s);
        check(s, ID);
        tlp_host_model_i.rd(4'h1, s);
        check(s, 8'hF0);
        for (int a = 2; a < 16; a++) begin
            tlp_host_model_i.rd(4'(a), s);
            check(s, 8'h00);
        end
        for (int a = 6; a < 16; a++) tlp_host_model_i.wr(4'(a), 8'hFF);
        tlp_host_model_i.rd(4'h1, s);
        check(s, 8'hF0);
        check(steps, 0);
        $display("t_regs done");
    endtask
    task automatic t_load();
        for (int j = 0; j < 48; j++) exp_q[j] = 8'h00;
        load(8'h11);
        tlp_host_model_i.rd(4'h1, s);
        check(s[5], 1'b0);
        for (int k = 1; k < 48; k++) load(8'h01 << (k % 8));
        print_chk();
        load(8'h80);
        load(8'h42);
        print_chk();
        $display("t_load done");
    endtask
    task automatic t_adv();
        s0 = steps;
        ready(8'h10);
        tlp_host_model_i.wr(4'h1, 8'h00);
        tlp_host_model_i.rd(4'h1, s);
        check(s[4], 1'b0);
        ready(8'h10);
        check(steps, s0 + 1);
        ready(8'h50);
        tlp_host_model_i.wr(4'h4, 8'h00);
        tlp_host_model_i.rd(4'h1, s);
        check(s & 8'h50, 8'h00);
        check(head_energize, 1'b1);
        check(steps, s0 + 1);
        ready(8'h50);
        check(steps, s0 + 2);
        tlp_host_model_i.wr(4'h1, 8'h00);
        tlp_host_model_i.wr(4'h0, 8'h00);
        tlp_host_model_i.rd(4'h1, s);
        check(s, 8'hF0);
        $display("t_adv done");
    endtask
    task automatic t_fault();
        head_fault <= 1'b1;
        tlp_host_model_i.rd(4'h1, s);
        check(s, 8'h00);
        tlp_host_model_i.wr(4'h5, 8'h00);
        // A print taken by mistake would show on the head one edge later
        @(posedge mclk);
        check(head_energize, 1'b0);
        head_fault <= 1'b0;
        tlp_host_model_i.rd(4'h1, s);
        check(s, 8'hF0);
        $display("t_fault done");
    endtask
    initial begin
        rst_n = 1'b0;
        head_fault = 1'b0;
        repeat (16) @(posedge mclk);
        rst_n <= 1'b1;
        t_regs();
        t_load();
        t_adv();
        t_fault();
        print_verdict();
    end
    // Whole run takes a few thousand cycles; this is far beyond it
    initial begin
        #2000000;
        err_total++;
        print_verdict();
    end
endmodule
